// file: logic/sensor_ctrl_regs_89_a9.sv
// sensor control register bank, offsets 0x89 to 0xA9, with steered control outputs
//
// Overview of operation
// - gamma segment fifteen output byte, reset E5
// - 12-bit colour enable only with RGB format
// - bit 0 picks padding nibble first or last
// - dummy lines: low byte, then high byte
// - lens options act only with lens enable
// - 50 Hz filter used when banding on, 50
// - 60 Hz filter used when banding on, 60
// - scaling delay in bits 6:0, reset 02
// - bit 3: double exposure or halve rate
// - bits 1:0 pick dummy-row gain point
// - 50 Hz banding step limit byte, reset 0F
// - six histogram tuning bytes with given resets
// - histogram bytes act only in histogram mode
`timescale 1ns/1ps

module sensor_ctrl_regs_89_a9 (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // register port from the serial control bus slave
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic             reg_hit,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  // enables held in registers outside this bank
  input  wire logic        rgb_family_sel,
  input  wire logic        lens_corr_enable,
  input  wire logic        banding_filter_en,
  input  wire logic        banding_freq_50hz,
  input  wire logic        expo_algorithm_hist,
  // gamma
  output logic [7:0]       gamma_seg15_out,
  // colour word
  output logic             rgb12_enable,
  output logic             rgb12_pad_last,
  // dummy lines
  output logic [15:0]      dummy_line_count,
  // lens correction
  output logic             lens_opt_valid,
  output logic [7:0]       lens_opt_a,
  output logic [7:0]       lens_opt_b,
  // banding
  output logic             band_filter_valid,
  output logic [7:0]       band_filter_value,
  output logic [7:0]       band_step_limit_50hz,
  // scaling
  output logic [6:0]       scale_out_delay,
  // automatic frame rate
  output logic             afr_halve_rate,
  output logic [1:0]       afr_gain_point,
  // histogram exposure tuning
  output logic             hist_tuning_valid,
  output logic [47:0]      hist_tuning
);

  localparam int unsigned NR = sensor_bank_pkg::NUM_REGS;

  logic [7:0] regs_q [NR];
  logic       hit;
  logic [4:0] slot;

  // maps an address to its storage slot; hit low for reserved or foreign addresses
  function automatic logic [5:0] decode(input logic [7:0] addr);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 0; i < NR; i++) begin
      if (addr == sensor_bank_pkg::REG_OFS[i]) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction

  assign {hit, slot} = decode(reg_addr);
  assign reg_hit = hit;

  // storage: writes to unmapped addresses are dropped
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NR; i++) begin
        regs_q[i] <= sensor_bank_pkg::REG_RST[i];
      end
    end else if (reg_wr && hit) begin
      regs_q[slot] <= reg_wdata;
    end
  end

  // read back: whole stored byte, reserved addresses read 00
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= hit ? regs_q[slot] : 8'h00;
      end
    end
  end

  // gamma and colour word
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gamma_seg15_out <= sensor_bank_pkg::GAMMA_LAST_SEGMENT_RST;
      rgb12_enable    <= 1'b0;
      rgb12_pad_last  <= 1'b0;
    end else begin
      gamma_seg15_out <= regs_q[sensor_bank_pkg::IDX_GAMMA];
      rgb12_enable    <= rgb_family_sel &&
        regs_q[sensor_bank_pkg::IDX_COLOUR][sensor_bank_pkg::RGB12_ENABLE_BIT];
      rgb12_pad_last  <=
        regs_q[sensor_bank_pkg::IDX_COLOUR][sensor_bank_pkg::RGB12_PAD_LAST_BIT];
    end
  end

  // dummy lines and lens correction
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dummy_line_count <= {sensor_bank_pkg::DUMMY_LINE_HIGH_RST,
                           sensor_bank_pkg::DUMMY_LINE_LOW_RST};
      lens_opt_valid   <= 1'b0;
      lens_opt_a       <= sensor_bank_pkg::LENS_CORR_OPTION_A_RST;
      lens_opt_b       <= sensor_bank_pkg::LENS_CORR_OPTION_B_RST;
    end else begin
      dummy_line_count <= {regs_q[sensor_bank_pkg::IDX_DUMMY_HI],
                           regs_q[sensor_bank_pkg::IDX_DUMMY_LO]};
      lens_opt_valid   <= lens_corr_enable;
      lens_opt_a       <= regs_q[sensor_bank_pkg::IDX_LENS_A];
      lens_opt_b       <= regs_q[sensor_bank_pkg::IDX_LENS_B];
    end
  end

  // banding filter: value picked by frequency, flagged unused when banding is off
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      band_filter_valid    <= 1'b0;
      band_filter_value    <= 8'h00;
      band_step_limit_50hz <= sensor_bank_pkg::BAND_STEP_LIMIT_50HZ_RST;
    end else begin
      band_filter_valid <= banding_filter_en;
      if (!banding_filter_en) begin
        band_filter_value <= 8'h00;
      end else if (banding_freq_50hz) begin
        band_filter_value <= regs_q[sensor_bank_pkg::IDX_BAND50];
      end else begin
        band_filter_value <= regs_q[sensor_bank_pkg::IDX_BAND60];
      end
      band_step_limit_50hz <= regs_q[sensor_bank_pkg::IDX_STEP50];
    end
  end

  // scaling delay and automatic frame rate policy
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      scale_out_delay <= sensor_bank_pkg::SCALED_OUTPUT_DELAY_RST[sensor_bank_pkg::SCALE_DELAY_LSB
                         +: sensor_bank_pkg::SCALE_DELAY_W];
      afr_halve_rate  <= 1'b0;
      afr_gain_point  <= 2'h0;
    end else begin
      scale_out_delay <= regs_q[sensor_bank_pkg::IDX_DELAY][sensor_bank_pkg::SCALE_DELAY_LSB
                         +: sensor_bank_pkg::SCALE_DELAY_W];
      afr_halve_rate  <=
        regs_q[sensor_bank_pkg::IDX_NIGHT][sensor_bank_pkg::AFR_HALVE_RATE_BIT];
      afr_gain_point  <= regs_q[sensor_bank_pkg::IDX_NIGHT][sensor_bank_pkg::AFR_GAIN_LSB
                         +: sensor_bank_pkg::AFR_GAIN_W];
    end
  end

  // histogram tuning bytes, byte a in the low lane
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hist_tuning_valid <= 1'b0;
      hist_tuning       <= 48'h0;
    end else begin
      hist_tuning_valid <= expo_algorithm_hist;
      hist_tuning <= {regs_q[sensor_bank_pkg::IDX_HIST_F], regs_q[sensor_bank_pkg::IDX_HIST_E],
                      regs_q[sensor_bank_pkg::IDX_HIST_D], regs_q[sensor_bank_pkg::IDX_HIST_C],
                      regs_q[sensor_bank_pkg::IDX_HIST_B],
                      regs_q[sensor_bank_pkg::IDX_HIST_A]};
    end
  end

endmodule // sensor_ctrl_regs_89_a9

// file: logic/sensor_bank_pkg.sv
// package: offsets, field positions and reset values of the sensor control bank
package sensor_bank_pkg;

  localparam int unsigned NUM_REGS = 17;

  // register offsets on the control register port
  localparam logic [7:0] GAMMA_LAST_SEGMENT_OFS    = 8'h89;
  localparam logic [7:0] COLOUR_WORD_FORMAT_OFS    = 8'h8C;
  localparam logic [7:0] DUMMY_LINE_LOW_OFS        = 8'h92;
  localparam logic [7:0] DUMMY_LINE_HIGH_OFS       = 8'h93;
  localparam logic [7:0] LENS_CORR_OPTION_A_OFS    = 8'h94;
  localparam logic [7:0] LENS_CORR_OPTION_B_OFS    = 8'h95;
  localparam logic [7:0] BAND_FILTER_50HZ_OFS      = 8'h9D;
  localparam logic [7:0] BAND_FILTER_60HZ_OFS      = 8'h9E;
  localparam logic [7:0] HIST_EXPO_CTRL_A_OFS      = 8'h9F;
  localparam logic [7:0] HIST_EXPO_CTRL_B_OFS      = 8'hA0;
  localparam logic [7:0] SCALED_OUTPUT_DELAY_OFS   = 8'hA2;
  localparam logic [7:0] NIGHT_FRAME_RATE_CTRL_OFS = 8'hA4;
  localparam logic [7:0] BAND_STEP_LIMIT_50HZ_OFS  = 8'hA5;
  localparam logic [7:0] HIST_EXPO_CTRL_C_OFS      = 8'hA6;
  localparam logic [7:0] HIST_EXPO_CTRL_D_OFS      = 8'hA7;
  localparam logic [7:0] HIST_EXPO_CTRL_E_OFS      = 8'hA8;
  localparam logic [7:0] HIST_EXPO_CTRL_F_OFS      = 8'hA9;

  // reset values
  localparam logic [7:0] GAMMA_LAST_SEGMENT_RST    = 8'hE5;
  localparam logic [7:0] COLOUR_WORD_FORMAT_RST    = 8'h00;
  localparam logic [7:0] DUMMY_LINE_LOW_RST        = 8'h00;
  localparam logic [7:0] DUMMY_LINE_HIGH_RST       = 8'h00;
  localparam logic [7:0] LENS_CORR_OPTION_A_RST    = 8'h50;
  localparam logic [7:0] LENS_CORR_OPTION_B_RST    = 8'h50;
  localparam logic [7:0] BAND_FILTER_50HZ_RST      = 8'h99;
  localparam logic [7:0] BAND_FILTER_60HZ_RST      = 8'h7F;
  localparam logic [7:0] HIST_EXPO_CTRL_A_RST      = 8'hC0;
  localparam logic [7:0] HIST_EXPO_CTRL_B_RST      = 8'h90;
  localparam logic [7:0] SCALED_OUTPUT_DELAY_RST   = 8'h02;
  localparam logic [7:0] NIGHT_FRAME_RATE_CTRL_RST = 8'h00;
  localparam logic [7:0] BAND_STEP_LIMIT_50HZ_RST  = 8'h0F;
  localparam logic [7:0] HIST_EXPO_CTRL_C_RST      = 8'hF0;
  localparam logic [7:0] HIST_EXPO_CTRL_D_RST      = 8'hC1;
  localparam logic [7:0] HIST_EXPO_CTRL_E_RST      = 8'hF0;
  localparam logic [7:0] HIST_EXPO_CTRL_F_RST      = 8'hC1;

  // field positions
  localparam int unsigned RGB12_ENABLE_BIT   = 1;
  localparam int unsigned RGB12_PAD_LAST_BIT = 0;
  localparam int unsigned AFR_HALVE_RATE_BIT = 3;
  localparam int unsigned AFR_GAIN_LSB       = 0;
  localparam int unsigned AFR_GAIN_W         = 2;
  localparam int unsigned SCALE_DELAY_LSB    = 0;
  localparam int unsigned SCALE_DELAY_W      = 7;

  // storage slot order; the two tables below follow it
  localparam logic [7:0] REG_OFS [NUM_REGS] = '{
    GAMMA_LAST_SEGMENT_OFS, COLOUR_WORD_FORMAT_OFS, DUMMY_LINE_LOW_OFS,
    DUMMY_LINE_HIGH_OFS, LENS_CORR_OPTION_A_OFS, LENS_CORR_OPTION_B_OFS,
    BAND_FILTER_50HZ_OFS, BAND_FILTER_60HZ_OFS, HIST_EXPO_CTRL_A_OFS,
    HIST_EXPO_CTRL_B_OFS, SCALED_OUTPUT_DELAY_OFS, NIGHT_FRAME_RATE_CTRL_OFS,
    BAND_STEP_LIMIT_50HZ_OFS, HIST_EXPO_CTRL_C_OFS, HIST_EXPO_CTRL_D_OFS,
    HIST_EXPO_CTRL_E_OFS, HIST_EXPO_CTRL_F_OFS};

  localparam logic [7:0] REG_RST [NUM_REGS] = '{
    GAMMA_LAST_SEGMENT_RST, COLOUR_WORD_FORMAT_RST, DUMMY_LINE_LOW_RST,
    DUMMY_LINE_HIGH_RST, LENS_CORR_OPTION_A_RST, LENS_CORR_OPTION_B_RST,
    BAND_FILTER_50HZ_RST, BAND_FILTER_60HZ_RST, HIST_EXPO_CTRL_A_RST,
    HIST_EXPO_CTRL_B_RST, SCALED_OUTPUT_DELAY_RST, NIGHT_FRAME_RATE_CTRL_RST,
    BAND_STEP_LIMIT_50HZ_RST, HIST_EXPO_CTRL_C_RST, HIST_EXPO_CTRL_D_RST,
    HIST_EXPO_CTRL_E_RST, HIST_EXPO_CTRL_F_RST};

  // slot indices used by the steering logic
  localparam int unsigned IDX_GAMMA = 0;
  localparam int unsigned IDX_COLOUR = 1;
  localparam int unsigned IDX_DUMMY_LO = 2;
  localparam int unsigned IDX_DUMMY_HI = 3;
  localparam int unsigned IDX_LENS_A = 4;
  localparam int unsigned IDX_LENS_B = 5;
  localparam int unsigned IDX_BAND50 = 6;
  localparam int unsigned IDX_BAND60 = 7;
  localparam int unsigned IDX_HIST_A = 8;
  localparam int unsigned IDX_HIST_B = 9;
  localparam int unsigned IDX_DELAY = 10;
  localparam int unsigned IDX_NIGHT = 11;
  localparam int unsigned IDX_STEP50 = 12;
  localparam int unsigned IDX_HIST_C = 13;
  localparam int unsigned IDX_HIST_D = 14;
  localparam int unsigned IDX_HIST_E = 15;
  localparam int unsigned IDX_HIST_F = 16;

endpackage

// file: dv/sensor_ctrl_regs_89_a9_sva.sv
// checker: port-level properties of the sensor control bank
`timescale 1ns/1ps
module sensor_regs_sva (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        reg_hit,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  // control inputs and outputs
  input wire logic        rgb_family_sel,
  input wire logic        lens_corr_enable,
  input wire logic        banding_filter_en,
  input wire logic        expo_algorithm_hist,
  input wire logic        rgb12_enable,
  input wire logic [15:0] dummy_line_count,
  input wire logic        lens_opt_valid,
  input wire logic        band_filter_valid,
  input wire logic [7:0]  band_filter_value,
  input wire logic [6:0]  scale_out_delay,
  input wire logic        hist_tuning_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rd_pulse_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without read");
  reserved_zero_a: assert property (reg_rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  rgb12_gate_a: assert property (rgb12_enable |-> $past(rgb_family_sel))
    else $error("rgb12 enabled without rgb format");
  band_off_a: assert property (
    !banding_filter_en |=> !band_filter_valid && band_filter_value == 8'h00)
    else $error("band value not cleared");
  lens_flag_a: assert property (1'b1 |=> lens_opt_valid == $past(lens_corr_enable))
    else $error("lens valid mismatch");
  hist_flag_a: assert property (
    1'b1 |=> hist_tuning_valid == $past(expo_algorithm_hist))
    else $error("hist valid mismatch");
  dummy_low_a: assert property (
    reg_wr && reg_addr == 8'h92 |=> ##1 dummy_line_count[7:0] == $past(reg_wdata, 2))
    else $error("dummy low byte wrong");
  scale_dly_a: assert property (
    reg_wr && reg_addr == 8'hA2 |=> ##1 scale_out_delay == 7'($past(reg_wdata, 2)))
    else $error("scale delay wrong");
  cov_rd: cover property (reg_rd && reg_hit);
  cov_rsvd: cover property (reg_rd && !reg_hit);
  cov_band: cover property (band_filter_valid);
endmodule // sensor_regs_sva

bind sensor_ctrl_regs_89_a9 sensor_regs_sva sva (.clk_sys, .resetn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_hit, .reg_rdata, .reg_rvalid, .rgb_family_sel, .lens_corr_enable,
  .banding_filter_en, .expo_algorithm_hist, .rgb12_enable, .dummy_line_count, .lens_opt_valid,
  .band_filter_valid, .band_filter_value, .scale_out_delay, .hist_tuning_valid);

// file: dv/host_ctrl_model.sv
// partner: control bus host issuing byte writes and reads
`timescale 1ns/1ps
module host_ctrl_model (
  // clock
  input wire logic       clk_sys,
  // register port
  output logic [7:0]     reg_addr,
  output logic [7:0]     reg_wdata,
  output logic           reg_wr,
  output logic           reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // idle bus shows inverted values so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    ok = reg_rvalid;
  endtask
endmodule // host_ctrl_model

// file: dv/test_sensor_ctrl_regs_89_a9.sv
// testbench: sensor control bank against a byte-array model
`timescale 1ns/1ps
module test_sensor_ctrl_regs_89_a9;
  logic        clk_sys = 1'b0, resetn = 1'b0, reg_wr, reg_rd, reg_hit, reg_rvalid;
  logic        rgb_family_sel = 1'b0, lens_corr_enable = 1'b0, banding_filter_en = 1'b0;
  logic        banding_freq_50hz = 1'b0, expo_algorithm_hist = 1'b0, rgb12_enable;
  logic        rgb12_pad_last, lens_opt_valid, band_filter_valid, afr_halve_rate;
  logic        hist_tuning_valid;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, gamma_seg15_out, lens_opt_a, lens_opt_b;
  logic [7:0]  band_filter_value, band_step_limit_50hz, m [256];
  logic [15:0] dummy_line_count;
  logic [6:0]  scale_out_delay;
  logic [1:0]  afr_gain_point;
  logic [47:0] hist_tuning;
  bit          mapped [256];
  int          failures = 0, total_checks = 0;

  sensor_ctrl_regs_89_a9 uut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_hit, .reg_rdata, .reg_rvalid, .rgb_family_sel, .lens_corr_enable, .banding_filter_en,
    .banding_freq_50hz, .expo_algorithm_hist, .gamma_seg15_out, .rgb12_enable, .rgb12_pad_last,
    .dummy_line_count, .lens_opt_valid, .lens_opt_a, .lens_opt_b, .band_filter_valid,
    .band_filter_value, .band_step_limit_50hz, .scale_out_delay, .afr_halve_rate,
    .afr_gain_point, .hist_tuning_valid, .hist_tuning);
  host_ctrl_model host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid);

  always #2 clk_sys = ~clk_sys;

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic outs();
    chk(gamma_seg15_out === m[8'h89], "gamma byte");
    chk(rgb12_enable === (m[8'h8C][1] & rgb_family_sel), "rgb12 enable");
    chk(rgb12_pad_last === m[8'h8C][0], "pad order");
    chk(dummy_line_count === {m[8'h93], m[8'h92]}, "dummy count");
    chk({lens_opt_valid, lens_opt_a, lens_opt_b} === {lens_corr_enable, m[8'h94], m[8'h95]},
      "lens options");
    chk({band_filter_valid, band_filter_value} === {banding_filter_en, banding_filter_en ?
      (banding_freq_50hz ? m[8'h9D] : m[8'h9E]) : 8'h00}, "band value");
    chk(scale_out_delay === m[8'hA2][6:0], "scale delay");
    chk(afr_halve_rate === m[8'hA4][3], "afr policy");
    chk(afr_gain_point === m[8'hA4][1:0], "afr gain point");
    chk(band_step_limit_50hz === m[8'hA5], "step limit");
    chk({hist_tuning_valid, hist_tuning} === {expo_algorithm_hist, m[8'hA9], m[8'hA8],
      m[8'hA7], m[8'hA6], m[8'hA0], m[8'h9F]}, "hist bytes");
  endtask

  task automatic rdchk(input logic [7:0] a);
    logic [7:0] d;
    logic ok;
    fork
      host.rd(a, d, ok);
      begin
        @(negedge clk_sys);
        @(posedge clk_sys);
        chk(reg_hit === mapped[a], "address hit");
      end
    join
    chk(ok === 1'b1 && d === (mapped[a] ? m[a] : 8'h00), "read back");
  endtask

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (mapped[a]) m[a] = d;
    {rgb_family_sel, lens_corr_enable, banding_filter_en, banding_freq_50hz,
      expo_algorithm_hist} = 5'($urandom);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #20000;
    failures++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(46));
    foreach (m[i]) m[i] = 8'h00;
    for (int k = 0; k < sensor_bank_pkg::NUM_REGS; k++) begin
      m[sensor_bank_pkg::REG_OFS[k]] = sensor_bank_pkg::REG_RST[k];
      mapped[sensor_bank_pkg::REG_OFS[k]] = 1'b1;
    end
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    @(negedge clk_sys);
    outs();
    for (int i = 8'h88; i <= 8'hAA; i++) rdchk(8'(i));
    repeat (40) begin
      put(8'(8'h88 + $urandom_range(34)), 8'($urandom));
      @(negedge clk_sys);
      outs();
      rdchk(host.reg_addr ^ 8'hFF);
    end
    for (int g = 0; g < 16; g++) begin
      put(8'hA4, 8'(g));
      put(8'h8C, 8'(g));
      @(negedge clk_sys);
      outs();
    end
    tally_and_finish();
  end
endmodule // test_sensor_ctrl_regs_89_a9
